// ### mlm_monitor.sv
// module: maintenance life monitor with APB register slave
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RQ1 - capacitor at or below 85 percent sets bit1
// RQ2 - control codes 0,1,2,3,8,9; only 0,1 writable
// RQ3 - armed measurement starts at supply off
// RQ4 - excite motor for one second
// RQ5 - early power return may leave code 2
// RQ6 - start, shutoff, input, trip force end
// RQ7 - fan at half speed sets bit2, indication
// RQ8 - any single slow fan raises fault
// RQ9 - count whole powered hours, commit hourly
// RQ10 - timer in 100h units, saturates 9998
// RQ11 - timer read-only; writing zero clears it
// RQ12 - alarm at threshold; 9999 disables
// RQ13 - twenty second pulse cycle at constant speed
// RQ14 - mask time after reaching constant speed
// RQ15 - one second start pulse, current averaged
// RQ16 - current low time is ratio times 5s
// RQ17 - current low limited to 0.5 to 9s
// RQ18 - reference current 0 to 500 A
// RQ19 - maintenance high time from timer value
// RQ20 - maintenance high limited to 2 to 9s
// RQ21 - code 93/193 routes pulse, not output seven
// RQ22 - code 95/195 routes maintenance alarm
// RQ23 - life alarm when any status bit set
// RQ24 - speed loss in start pulse: 3.5s/16.5s
// RQ25 - rest of cycle driven low
// RQ26 - timing from 0.1 second prescaled tick
module mlm_monitor #(
   parameter int TICK_DIV = mlm_pkg::TICK_CYCLES,
   parameter int HOUR_DIV = mlm_pkg::HOUR_TICKS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        supply_on,
   input  wire logic        start_cmd,
   input  wire logic        output_shutoff_input,
   input  wire logic        control_input_active,
   input  wire logic        trip,
   input  wire logic        cap_meas_valid,
   input  wire logic [15:0] cap_meas_percent,
   input  wire logic [3:0]  fan_slow,
   input  wire logic        ctrl_cap_alarm,
   input  wire logic        inrush_alarm,
   input  wire logic        const_speed,
   input  wire logic [15:0] output_current,
   output logic             motor_excite,
   output logic             nvm_commit,
   output logic             fan_fault_indication,
   output logic             life_alarm_out,
   output logic             maint_alarm_out,
   output logic             current_avg_pulse_out,
   output logic             y0_out,
   output logic             virtual_output_seven
);
   typedef enum logic [2:0] {MLM_IDLE, MLM_MASK, MLM_START, MLM_CUR, MLM_MNT, MLM_TAIL,
                             MLM_BAD_HI, MLM_BAD_LO} mlm_pulse_e;

   // two-flop synchronisers for pins
   logic [10:0] sync1_q, sync2_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sync1_q <= 11'h000;
         sync2_q <= 11'h000;
      end
      else if (clk_en)
      begin
         sync1_q <= {supply_on, start_cmd, output_shutoff_input, control_input_active, trip,
                     fan_slow, ctrl_cap_alarm, inrush_alarm};
         sync2_q <= sync1_q;
      end
   logic s_supply, s_start, s_shut, s_ctl, s_trip, s_fan, s_ccap, s_inrush;
   assign s_supply = sync2_q[10];
   assign s_start  = sync2_q[9];
   assign s_shut   = sync2_q[8];
   assign s_ctl    = sync2_q[7];
   assign s_trip   = sync2_q[6];
   assign s_fan    = |sync2_q[5:2]; // see RQ8
   assign s_ccap   = sync2_q[1];
   assign s_inrush = sync2_q[0];

   // 0.1 s tick
   logic [23:0] pre_q;
   logic        tick;
   assign tick = clk_en && (pre_q == 24'(TICK_DIV - 1));
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pre_q <= 24'h000000;
      else if (clk_en)
         pre_q <= tick ? 24'h000000 : pre_q + 24'h000001; // see RQ26

   // apb decode
   logic wr, rd;
   assign wr      = psel && penable && pwrite && clk_en;
   assign rd      = psel && penable && !pwrite;
   assign pready  = 1'b1;
   function automatic logic hit(input logic [7:0] off);
      return paddr == off;
   endfunction
   logic mapped;
   assign mapped  = (paddr <= mlm_pkg::OFF_STATUS) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !mapped;

   logic [15:0] thresh_q, window_q, mask_q, ref_q;
   logic [7:0]  func_y0_q, func_v7_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         thresh_q  <= mlm_pkg::THRESH_RESET;
         window_q  <= mlm_pkg::AVG_WINDOW_RESET;
         mask_q    <= mlm_pkg::MASK_TIME_RESET;
         ref_q     <= mlm_pkg::REF_CURRENT_RESET;
         func_y0_q <= 8'h00;
         func_v7_q <= 8'h00;
      end
      else if (wr)
      begin
         if (hit(mlm_pkg::OFF_ALARM_THRESH) && pwdata[15:0] <= mlm_pkg::THRESH_RESET)
            thresh_q <= pwdata[15:0];
         if (hit(mlm_pkg::OFF_AVG_WINDOW) && pwdata[15:0] >= 16'h0001 && pwdata[15:0] <= 16'h000A)
            window_q <= pwdata[15:0];
         if (hit(mlm_pkg::OFF_MASK_TIME) && pwdata[15:0] <= 16'h00C8) // see RQ14
            mask_q <= pwdata[15:0];
         if (hit(mlm_pkg::OFF_REF_CURRENT) && pwdata[15:0] <= 16'h01F4) // see RQ18
            ref_q <= pwdata[15:0];
         if (hit(mlm_pkg::OFF_OUT_FUNC))
         begin
            func_y0_q <= pwdata[7:0];
            if (pwdata[15:8] != mlm_pkg::FUNC_CUR_POS && pwdata[15:8] != mlm_pkg::FUNC_CUR_NEG)
               func_v7_q <= pwdata[15:8]; // see RQ21
         end
      end

   // capacitor measurement
   logic [3:0]  cap_code_q;
   logic [15:0] cap_pct_q;
   logic [7:0]  exc_q;
   logic        cap_alarm_q;
   logic        abort;
   assign abort = s_start || s_shut || s_ctl || s_trip;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cap_code_q  <= mlm_pkg::CAP_IDLE;
         cap_pct_q   <= 16'h0064;
         exc_q       <= 8'h00;
         cap_alarm_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr && hit(mlm_pkg::OFF_CAP_CTRL) && pwdata[15:0] <= 16'h0001)
            cap_code_q <= pwdata[3:0]; // see RQ2, RQ5
         else case (cap_code_q)
            mlm_pkg::CAP_ARMED:
               if (!s_supply && !abort)
               begin
                  cap_code_q <= mlm_pkg::CAP_RUNNING; // see RQ3
                  exc_q      <= mlm_pkg::EXCITE_TICKS;
               end
            mlm_pkg::CAP_RUNNING:
               if (s_trip)
                  cap_code_q <= mlm_pkg::CAP_ERROR; // see RQ6
               else if (s_start || s_shut || s_ctl)
                  cap_code_q <= mlm_pkg::CAP_FORCED;
               else if (exc_q != 8'h00)
               begin
                  if (tick)
                     exc_q <= exc_q - 8'h01; // see RQ4
               end
               else if (cap_meas_valid && !s_supply)
               begin
                  cap_code_q  <= mlm_pkg::CAP_DONE;
                  cap_pct_q   <= cap_meas_percent;
                  cap_alarm_q <= cap_meas_percent <= mlm_pkg::CAP_ALARM_PCT; // see RQ1
               end
            default: ;
         endcase
         if (s_supply && cap_code_q == mlm_pkg::CAP_RUNNING)
            exc_q <= 8'h00; // see RQ5
      end
   assign motor_excite = (cap_code_q == mlm_pkg::CAP_RUNNING) && (exc_q != 8'h00) && !s_supply;

   logic [3:0] life_status;
   assign life_status          = {s_inrush, s_fan, cap_alarm_q, s_ccap}; // see RQ7
   assign fan_fault_indication = s_fan;
   assign life_alarm_out       = |life_status; // see RQ23, RQ1

   // energization hours
   logic [15:0] hr_tick_q;
   logic [6:0]  hr_q;
   logic [15:0] maint_q;
   logic        commit_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         hr_tick_q <= 16'h0000;
         hr_q      <= 7'h00;
         maint_q   <= 16'h0000;
         commit_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         commit_q <= 1'b0;
         if (!s_supply)
            hr_tick_q <= 16'h0000; // see RQ9
         else if (tick)
         begin
            if (hr_tick_q == 16'(HOUR_DIV - 1))
            begin
               hr_tick_q <= 16'h0000;
               commit_q  <= 1'b1;
               if (hr_q == 7'(mlm_pkg::HOURS_PER_UNIT - 1))
               begin
                  hr_q <= 7'h00;
                  if (maint_q < mlm_pkg::MAINT_MAX)
                     maint_q <= maint_q + 16'h0001; // see RQ10
               end
               else
                  hr_q <= hr_q + 7'h01;
            end
            else
               hr_tick_q <= hr_tick_q + 16'h0001;
         end
         if (wr && hit(mlm_pkg::OFF_ENERG_HOURS) && pwdata[15:0] == 16'h0000 && maint_q != 16'h0000)
         begin
            maint_q <= 16'h0000; // see RQ11
            hr_q    <= 7'h00;
         end
      end
   assign nvm_commit = commit_q;

   logic maint_alarm;
   assign maint_alarm     = (thresh_q != mlm_pkg::THRESH_RESET) && (maint_q >= thresh_q); // see RQ12
   assign maint_alarm_out = maint_alarm;

   // pulse time helpers
   function automatic logic [7:0] cur_ticks(input logic [15:0] avg, input logic [15:0] refc);
      logic [31:0] t;
      t = 32'h0;
      if (refc == 16'h0000 || 32'(avg) * 32'd10 > 32'(refc) * 32'd18)
         return mlm_pkg::T_CUR_MAX; // see RQ17
      if (32'(avg) * 32'd10 < 32'(refc))
         return mlm_pkg::T_CUR_MIN;
      t = 32'(avg) * 32'(mlm_pkg::PULSE_FULL) / 32'(refc); // see RQ16
      return (t < 32'(mlm_pkg::T_CUR_MIN)) ? mlm_pkg::T_CUR_MIN : t[7:0];
   endfunction
   function automatic logic [7:0] mnt_ticks(input logic [15:0] units);
      logic [31:0] t;
      t = 32'(units) * 32'(mlm_pkg::PULSE_FULL) / 32'(mlm_pkg::MNT_FULL_UNITS); // see RQ19
      if (units < mlm_pkg::MNT_LOW_UNITS)
         return mlm_pkg::T_MNT_MIN; // see RQ20
      if (units > mlm_pkg::MNT_HIGH_UNITS)
         return mlm_pkg::T_MNT_MAX;
      return t[7:0];
   endfunction

   // current average pulse sequencer
   mlm_pulse_e  st_q;
   logic [7:0]  tcnt_q, cyc_q;
   logic [19:0] acc_q;
   logic [15:0] avg_q;
   logic        pulse_q;
   logic [15:0] cur_s1_q, cur_s2_q, cur_s3_q, cur_ok_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cur_s1_q <= 16'h0000;
         cur_s2_q <= 16'h0000;
         cur_s3_q <= 16'h0000;
         cur_ok_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         cur_s1_q <= output_current;
         cur_s2_q <= cur_s1_q;
         cur_s3_q <= cur_s2_q;
         // word taken only once two samples agree
         if (cur_s2_q == cur_s3_q)
            cur_ok_q <= cur_s2_q;
      end
   logic const_s1_q, const_s2_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         const_s1_q <= 1'b0;
         const_s2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         const_s1_q <= const_speed;
         const_s2_q <= const_s1_q;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st_q    <= MLM_IDLE;
         tcnt_q  <= 8'h00;
         cyc_q   <= 8'h00;
         acc_q   <= 20'h00000;
         avg_q   <= 16'h0000;
         pulse_q <= 1'b0;
      end
      else if (clk_en && tick)
      begin
         cyc_q  <= cyc_q + 8'h01;
         tcnt_q <= tcnt_q + 8'h01;
         case (st_q)
            MLM_IDLE:
               if (const_s2_q)
               begin
                  st_q   <= MLM_MASK;
                  tcnt_q <= 8'h00;
               end
            MLM_MASK:
               if (!const_s2_q)
                  st_q <= MLM_IDLE;
               else if (16'(tcnt_q) >= mask_q) // see RQ14
               begin
                  st_q    <= MLM_START;
                  tcnt_q  <= 8'h00;
                  cyc_q   <= 8'h00;
                  acc_q   <= 20'h00000;
                  pulse_q <= 1'b1; // see RQ15
               end
            MLM_START:
               if (!const_s2_q)
                  st_q <= MLM_BAD_HI; // see RQ24
               else if (tcnt_q == mlm_pkg::T_START - 8'h01)
               begin
                  avg_q   <= 16'((acc_q + 20'(cur_ok_q)) / 20'(window_q));
                  st_q    <= MLM_CUR;
                  tcnt_q  <= 8'h00;
                  pulse_q <= 1'b0;
               end
               else if (16'(tcnt_q) >= 16'(mlm_pkg::T_START) - window_q)
                  acc_q <= acc_q + 20'(cur_ok_q); // see RQ15
            MLM_CUR:
               if (tcnt_q == cur_ticks(avg_q, ref_q) - 8'h01)
               begin
                  st_q    <= MLM_MNT;
                  tcnt_q  <= 8'h00;
                  pulse_q <= 1'b1;
               end
            MLM_MNT:
               if (tcnt_q == mnt_ticks(maint_q) - 8'h01)
               begin
                  st_q    <= MLM_TAIL;
                  pulse_q <= 1'b0; // see RQ25
               end
            MLM_TAIL:
               if (cyc_q == mlm_pkg::T_CYCLE - 8'h01)
               begin
                  cyc_q <= 8'h00;
                  tcnt_q <= 8'h00;
                  if (const_s2_q)
                  begin
                     st_q    <= MLM_START; // see RQ13
                     acc_q   <= 20'h00000;
                     pulse_q <= 1'b1;
                  end
                  else
                     st_q <= MLM_IDLE;
               end
            MLM_BAD_HI:
               if (cyc_q == mlm_pkg::T_START_BAD - 8'h01)
               begin
                  st_q    <= MLM_BAD_LO;
                  tcnt_q  <= 8'h00;
                  pulse_q <= 1'b0;
               end
            MLM_BAD_LO:
               if (tcnt_q == mlm_pkg::T_END_BAD - 8'h01)
                  st_q <= MLM_IDLE;
            default:
               st_q <= MLM_IDLE;
         endcase
      end
   assign current_avg_pulse_out = pulse_q;

   // output function routing
   function automatic logic route(input logic [7:0] f);
      case (f)
         mlm_pkg::FUNC_CUR_POS:   return pulse_q;
         mlm_pkg::FUNC_CUR_NEG:   return !pulse_q;
         mlm_pkg::FUNC_MAINT_POS: return maint_alarm;
         mlm_pkg::FUNC_MAINT_NEG: return !maint_alarm;
         default:                 return 1'b0;
      endcase
   endfunction
   assign y0_out               = route(func_y0_q); // see RQ21, RQ22
   assign virtual_output_seven = route(func_v7_q);

   // register read
   always_comb
   begin
      prdata = 32'h00000000;
      if (rd)
         case (paddr)
            mlm_pkg::OFF_LIFE_STATUS:  prdata = {28'h0, life_status};
            mlm_pkg::OFF_CAP_LIFE:     prdata = {16'h0, cap_pct_q};
            mlm_pkg::OFF_CAP_CTRL:     prdata = {28'h0, cap_code_q};
            mlm_pkg::OFF_ENERG_HOURS:  prdata = {16'h0, maint_q};
            mlm_pkg::OFF_ALARM_THRESH: prdata = {16'h0, thresh_q};
            mlm_pkg::OFF_AVG_WINDOW:   prdata = {16'h0, window_q};
            mlm_pkg::OFF_MASK_TIME:    prdata = {16'h0, mask_q};
            mlm_pkg::OFF_REF_CURRENT:  prdata = {16'h0, ref_q};
            mlm_pkg::OFF_OUT_FUNC:     prdata = {16'h0, func_v7_q, func_y0_q};
            mlm_pkg::OFF_STATUS:       prdata = {29'h0, maint_alarm, pulse_q, motor_excite};
            default:                   prdata = 32'h00000000;
         endcase
   end

   AST_CAP_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
      cap_alarm_q |-> life_alarm_out)
      else $error("cap alarm without life alarm"); // see RQ1
   AST_CODE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
      cap_code_q inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9})
      else $error("illegal measure code"); // see RQ2
   AST_MAINT_SAT: assert property (@(posedge pclk) disable iff (!presetn)
      maint_q <= mlm_pkg::MAINT_MAX)
      else $error("timer beyond clamp"); // see RQ10
   AST_MAINT_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
      (thresh_q == mlm_pkg::THRESH_RESET) |-> !maint_alarm_out)
      else $error("alarm while disabled"); // see RQ12
   AST_FAN: assert property (@(posedge pclk) disable iff (!presetn)
      s_fan |-> (life_alarm_out && life_status[2]))
      else $error("fan fault not flagged"); // see RQ7
   AST_V7: assert property (@(posedge pclk) disable iff (!presetn)
      func_v7_q != mlm_pkg::FUNC_CUR_POS && func_v7_q != mlm_pkg::FUNC_CUR_NEG)
      else $error("pulse on virtual output seven"); // see RQ21
   AST_EXCITE: assert property (@(posedge pclk) disable iff (!presetn)
      motor_excite |-> cap_code_q == mlm_pkg::CAP_RUNNING)
      else $error("excite outside measurement"); // see RQ4
   AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit(mlm_pkg::OFF_ENERG_HOURS) && pwdata[15:0] == 16'h0000) |=> maint_q == 16'h0000)
      else $error("timer not cleared"); // see RQ11
endmodule
`default_nettype wire

// ### mlm_monitor_tb_top.sv
// testbench: registers, alarms, timer and pulse output of the life monitor
`timescale 1ns/10ps
`default_nettype none
module mlm_monitor_tb_top;
   localparam int TD = 10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        supply_on, start_cmd, cap_meas_valid, inrush_alarm, const_speed;
   logic        trip, ctrl_cap_alarm, v7_out;
   logic [15:0] cap_meas_percent, output_current, seg_len;
   logic [3:0]  fan_slow;
   logic        motor_excite, nvm_commit, fan_fault_indication, life_alarm_out;
   logic        maint_alarm_out, current_avg_pulse_out, y0_out, seg_done;
   int          n_fail, tests_run, n;

   mlm_monitor #(.TICK_DIV(TD), .HOUR_DIV(3)) u_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .supply_on(supply_on), .start_cmd(start_cmd),
      .output_shutoff_input(1'b0), .control_input_active(1'b0), .trip(trip),
      .cap_meas_valid(cap_meas_valid), .cap_meas_percent(cap_meas_percent),
      .fan_slow(fan_slow), .ctrl_cap_alarm(ctrl_cap_alarm), .inrush_alarm(inrush_alarm),
      .const_speed(const_speed), .output_current(output_current),
      .motor_excite(motor_excite), .nvm_commit(nvm_commit),
      .fan_fault_indication(fan_fault_indication), .life_alarm_out(life_alarm_out),
      .maint_alarm_out(maint_alarm_out), .current_avg_pulse_out(current_avg_pulse_out),
      .y0_out(y0_out), .virtual_output_seven(v7_out));

   mlm_pulse_reader u_reader (.pclk(pclk), .presetn(presetn), .sig(current_avg_pulse_out),
      .seg_done(seg_done), .seg_len(seg_len));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task settle;
      repeat (4) @(posedge pclk);
   endtask

   task get_seg(input int exp);
      n = 0;
      do @(posedge pclk); while (seg_done !== 1'b1 && n++ < 4000);
      if (seg_done !== 1'b1) n_fail++;
      chk({16'h0000, seg_len}, 32'(exp));
   endtask

   task wait_excite;
      n = 0;
      while (motor_excite !== 1'b1 && n++ < 200) @(posedge pclk);
      if (motor_excite !== 1'b1) n_fail++;
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial
   begin
      #3_000_000;
      n_fail++;
      close_out();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, start_cmd, inrush_alarm} = '0;
      {const_speed, output_current, fan_slow, trip, ctrl_cap_alarm} = '0;
      supply_on = 1'b1;
      cap_meas_valid = 1'b1;
      cap_meas_percent = mlm_pkg::CAP_ALARM_PCT;
      n_fail = 0;
      tests_run = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h0);
      rdc(mlm_pkg::OFF_ALARM_THRESH, 32'h270F);
      rdc(mlm_pkg::OFF_AVG_WINDOW, 32'h000A);
      rdc(mlm_pkg::OFF_MASK_TIME, 32'h0);
      rdc(mlm_pkg::OFF_REF_CURRENT, 32'h0064);
      rdc(8'h3C, 32'h0);
      chk(er, 32'h1);
      // life alarm sources
      {inrush_alarm, ctrl_cap_alarm} <= 2'b11;
      settle();
      chk(life_alarm_out, 32'h1);
      fan_slow <= 4'h4;
      settle();
      chk(fan_fault_indication, 32'h1);
      rdc(mlm_pkg::OFF_LIFE_STATUS, 32'h000D);
      {inrush_alarm, ctrl_cap_alarm, fan_slow} <= '0;
      settle();
      chk(life_alarm_out, 32'h0);
      // hour commits and maintenance timer
      wr(mlm_pkg::OFF_ALARM_THRESH, 32'h1);
      chk(maint_alarm_out, 32'h0);
      while (nvm_commit !== 1'b1 && n++ < 100) @(posedge pclk);
      @(posedge pclk);
      n = 1;
      while (nvm_commit !== 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n), 32'(3 * TD));
      n = 0;
      while (maint_alarm_out !== 1'b1 && n++ < 5000) @(posedge pclk);
      rdc(mlm_pkg::OFF_ENERG_HOURS, 32'h1);
      wr(mlm_pkg::OFF_OUT_FUNC, {16'h0, mlm_pkg::FUNC_MAINT_POS, mlm_pkg::FUNC_MAINT_POS});
      chk(y0_out, 32'h1);
      chk(v7_out, 32'h1);
      wr(mlm_pkg::OFF_OUT_FUNC, {24'h0, mlm_pkg::FUNC_MAINT_NEG});
      chk(y0_out, 32'h0);
      wr(mlm_pkg::OFF_ENERG_HOURS, 32'h5);
      rdc(mlm_pkg::OFF_ENERG_HOURS, 32'h1);
      wr(mlm_pkg::OFF_ENERG_HOURS, 32'h0);
      rdc(mlm_pkg::OFF_ENERG_HOURS, 32'h0);
      chk(maint_alarm_out, 32'h0);
      wr(mlm_pkg::OFF_ALARM_THRESH, 32'h0);
      chk(maint_alarm_out, 32'h1);
      wr(mlm_pkg::OFF_ALARM_THRESH, 32'h2710);
      rdc(mlm_pkg::OFF_ALARM_THRESH, 32'h0);
      wr(mlm_pkg::OFF_ALARM_THRESH, 32'h270F);
      chk(maint_alarm_out, 32'h0);
      // pulse output: 150 A against 100 A reference
      wr(mlm_pkg::OFF_OUT_FUNC, {16'h0, mlm_pkg::FUNC_CUR_POS, mlm_pkg::FUNC_CUR_POS});
      rdc(mlm_pkg::OFF_OUT_FUNC, {24'h0, mlm_pkg::FUNC_CUR_POS});
      chk(v7_out, 32'h0);
      output_current <= 16'd150;
      const_speed <= 1'b1;
      n = 0;
      while (current_avg_pulse_out !== 1'b1 && n++ < 500) @(posedge pclk);
      chk(y0_out, {31'h0, current_avg_pulse_out});
      @(posedge pclk);
      get_seg(mlm_pkg::T_START * TD);
      get_seg(75 * TD);
      get_seg(mlm_pkg::T_MNT_MIN * TD);
      get_seg((mlm_pkg::T_CYCLE - mlm_pkg::T_START - 75 - mlm_pkg::T_MNT_MIN) * TD);
      repeat (20) @(posedge pclk);
      const_speed <= 1'b0;
      get_seg(mlm_pkg::T_START_BAD * TD);
      const_speed <= 1'b1;
      // end low, then idle detect tick and zero-length mask tick
      get_seg((mlm_pkg::T_END_BAD + 2) * TD);
      wr(mlm_pkg::OFF_OUT_FUNC, {24'h0, mlm_pkg::FUNC_CUR_NEG});
      chk(y0_out, {31'h0, ~current_avg_pulse_out});
      // capacitor measurement: early power return, forced end, completion
      wr(mlm_pkg::OFF_CAP_CTRL, 32'h3);
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h0);
      wr(mlm_pkg::OFF_CAP_CTRL, 32'h1);
      settle();
      chk(motor_excite, 32'h0);
      supply_on <= 1'b0;
      wait_excite();
      supply_on <= 1'b1;
      settle();
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h2);
      wr(mlm_pkg::OFF_CAP_CTRL, 32'h1);
      supply_on <= 1'b0;
      wait_excite();
      start_cmd <= 1'b1;
      settle();
      {supply_on, start_cmd} <= 2'b10;
      settle();
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h8);
      wr(mlm_pkg::OFF_CAP_CTRL, 32'h1);
      supply_on <= 1'b0;
      wait_excite();
      trip <= 1'b1;
      settle();
      {supply_on, trip} <= 2'b10;
      settle();
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h9);
      wr(mlm_pkg::OFF_CAP_CTRL, 32'h1);
      supply_on <= 1'b0;
      wait_excite();
      n = 0;
      while (motor_excite === 1'b1 && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      chk(n > 9 * TD && n <= 10 * TD, 32'h1);
      supply_on <= 1'b1;
      settle();
      rdc(mlm_pkg::OFF_CAP_CTRL, 32'h3);
      rdc(mlm_pkg::OFF_CAP_LIFE, 32'h0055);
      rdc(mlm_pkg::OFF_LIFE_STATUS, 32'h0002);
      chk(life_alarm_out, 32'h1);
      close_out();
   end
endmodule
`default_nettype wire

// ### mlm_pkg.sv
// package: register map, codes and timing for the maintenance life monitor
package mlm_pkg;
   localparam logic [7:0]  OFF_LIFE_STATUS   = 8'h00;
   localparam logic [7:0]  OFF_CAP_LIFE      = 8'h04;
   localparam logic [7:0]  OFF_CAP_CTRL      = 8'h08;
   localparam logic [7:0]  OFF_ENERG_HOURS   = 8'h0C;
   localparam logic [7:0]  OFF_ALARM_THRESH  = 8'h10;
   localparam logic [7:0]  OFF_AVG_WINDOW    = 8'h14;
   localparam logic [7:0]  OFF_MASK_TIME     = 8'h18;
   localparam logic [7:0]  OFF_REF_CURRENT   = 8'h1C;
   localparam logic [7:0]  OFF_OUT_FUNC      = 8'h20;
   localparam logic [7:0]  OFF_STATUS        = 8'h24;

   localparam logic [3:0]  CAP_IDLE          = 4'h0;
   localparam logic [3:0]  CAP_ARMED         = 4'h1;
   localparam logic [3:0]  CAP_RUNNING       = 4'h2;
   localparam logic [3:0]  CAP_DONE          = 4'h3;
   localparam logic [3:0]  CAP_FORCED        = 4'h8;
   localparam logic [3:0]  CAP_ERROR         = 4'h9;

   localparam logic [15:0] CAP_ALARM_PCT     = 16'h0055;
   localparam logic [15:0] MAINT_MAX         = 16'h270E;
   localparam logic [15:0] THRESH_RESET      = 16'h270F;
   localparam logic [15:0] AVG_WINDOW_RESET  = 16'h000A;
   localparam logic [15:0] MASK_TIME_RESET   = 16'h0000;
   localparam logic [15:0] REF_CURRENT_RESET = 16'h0064;
   localparam logic [7:0]  FUNC_CUR_POS      = 8'h5D;
   localparam logic [7:0]  FUNC_CUR_NEG      = 8'hC1;
   localparam logic [7:0]  FUNC_MAINT_POS    = 8'h5F;
   localparam logic [7:0]  FUNC_MAINT_NEG    = 8'hC3;

   localparam int          CLK_HZ            = 10_000_000;
   localparam int          TICK_MS           = 100;
   localparam int          TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
   localparam int          HOUR_S            = 3600;
   localparam int          HOUR_TICKS        = HOUR_S * 1000 / TICK_MS;
   localparam int          HOURS_PER_UNIT    = 100;
   localparam int          EXCITE_MS         = 1000;
   localparam logic [7:0]  EXCITE_TICKS      = 8'(EXCITE_MS / TICK_MS);
   // pulse times in 0.1 s ticks, maintenance timer limits in 100 h units
   localparam logic [7:0]  T_CYCLE           = 8'd200;
   localparam logic [7:0]  T_START           = 8'd10;
   localparam logic [7:0]  T_START_BAD       = 8'd35;
   localparam logic [7:0]  T_END_BAD         = 8'd165;
   localparam logic [7:0]  T_CUR_MIN         = 8'd5;
   localparam logic [7:0]  T_CUR_MAX         = 8'd90;
   localparam logic [7:0]  T_MNT_MIN         = 8'd20;
   localparam logic [7:0]  T_MNT_MAX         = 8'd90;
   localparam logic [15:0] MNT_LOW_UNITS     = 16'd160;
   localparam logic [15:0] MNT_HIGH_UNITS    = 16'd720;
   localparam logic [15:0] MNT_FULL_UNITS    = 16'd400;
   localparam logic [7:0]  PULSE_FULL        = 8'd50;
endpackage

// ### mlm_pulse_reader.sv
// partner model: controller input module timing pulse widths
`timescale 1ns/10ps
`default_nettype none
module mlm_pulse_reader (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sig,
   output logic             seg_done,
   output logic [15:0]      seg_len
);
   logic        last_q;
   logic [15:0] cnt_q;

   // times each level in clocks, reports it when the level ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_q   <= 1'b0;
         cnt_q    <= 16'h0001;
         seg_done <= 1'b0;
         seg_len  <= 16'h0000;
      end
      else if (sig != last_q)
      begin
         last_q   <= sig;
         cnt_q    <= 16'h0001;
         seg_done <= 1'b1;
         seg_len  <= cnt_q;
      end
      else
      begin
         cnt_q    <= cnt_q + 16'h0001;
         seg_done <= 1'b0;
      end
   end
endmodule
`default_nettype wire
